/* rtl/tmb_pkg.sv */
// Constants, register map and carrier types of the thermal model.
`default_nettype none

package tmb_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_MS = 100;
    localparam int TICK_CYCLES = TICK_MS * 1000000 / CLK_PERIOD_NS;
    localparam int TICKS_PER_MIN = 60000 / TICK_MS;

    // ------------------------------------------------------------------
    // Arithmetic constants
    // ------------------------------------------------------------------
    localparam logic [15:0] Q8_ONE = 16'h0100;
    localparam int Q8_SHIFT = 8;
    localparam int SQRT_SHIFT = 12;
    localparam logic [49:0] RADICAND_ONE = 50'h0000001000000;
    localparam logic [31:0] PCT_SCALE = 32'h00000064;
    localparam logic [23:0] TC_FULL = 24'h640000;
    localparam logic [23:0] TC_RISE_PCT_PER_MIN = 24'h050000;
    localparam logic [23:0] TC_RISE_PER_TICK = 24'(TC_RISE_PCT_PER_MIN / TICKS_PER_MIN);
    localparam logic [63:0] LEARN_K_NUM = 64'h00000000000000AF;
    localparam logic [15:0] AMBIENT_DEFAULT = 16'h0028;
    localparam logic [15:0] K_MAX = 16'hFFFF;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_FLA = 8'h04;
    localparam logic [7:0] ADDR_K_FACTOR = 8'h08;
    localparam logic [7:0] ADDR_HOT_COLD = 8'h0C;
    localparam logic [7:0] ADDR_OL_PICKUP = 8'h10;
    localparam logic [7:0] ADDR_SERVICE = 8'h14;
    localparam logic [7:0] ADDR_TAU_STOP = 8'h18;
    localparam logic [7:0] ADDR_TAU_RUN = 8'h1C;
    localparam logic [7:0] ADDR_BIAS_MIN = 8'h20;
    localparam logic [7:0] ADDR_BIAS_CEN = 8'h24;
    localparam logic [7:0] ADDR_BIAS_MAX = 8'h28;
    localparam logic [7:0] ADDR_TC = 8'h2C;
    localparam logic [7:0] ADDR_IEQ = 8'h30;
    localparam logic [7:0] ADDR_K_USED = 8'h34;
    localparam logic [7:0] ADDR_TAU_LEARN = 8'h38;
    localparam logic [7:0] ADDR_STATUS = 8'h3C;

    // Field positions.
    localparam int CTRL_K_LEARN_BIT = 0;
    localparam int CTRL_COOL_LEARN_BIT = 1;
    localparam int ST_TRIP_BIT = 0;
    localparam int ST_BIAS_FULL_BIT = 1;
    localparam int ST_HEATING_BIT = 2;

    // Reset values.
    localparam logic [1:0] RST_CTRL = 2'h0;
    localparam logic [15:0] RST_FLA = 16'h0064;
    localparam logic [15:0] RST_K = 16'h0000;
    localparam logic [15:0] RST_HOT_COLD = 16'h0100;
    localparam logic [15:0] RST_PICKUP = 16'h0103;
    localparam logic [15:0] RST_SERVICE = 16'h0100;
    localparam logic [15:0] RST_TAU_STOP = 16'h001E;
    localparam logic [15:0] RST_TAU_RUN = 16'h000F;
    localparam logic [15:0] RST_BIAS_MIN = 16'h0028;
    localparam logic [15:0] RST_BIAS_CEN = 16'h0082;
    localparam logic [15:0] RST_BIAS_MAX = 16'h009B;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {TMB_STOPPED, TMB_STARTING, TMB_RUNNING} tmb_motor_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } tmb_bus_req_t;

    typedef struct packed {
        logic [15:0] i_avg;
        logic [15:0] unbalance_fraction;
        logic [15:0] stator_temp;
        logic [15:0] ambient_temp;
        logic ambient_valid;
        logic [15:0] stator_cool_rate;
        logic [15:0] learned_start_current;
        tmb_motor_state_t motor_state;
        logic [15:0] curve_heat;
    } tmb_meas_t;

endpackage

`default_nettype wire

/* rtl/tmb_thermal_model.sv */
// Thermal capacity used model with unbalance bias, cooling and temperature bias.
`default_nettype none

module tmb_thermal_model #(
    parameter int TICK_CYCLES = tmb_pkg::TICK_CYCLES
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Register port.
    input wire tmb_pkg::tmb_bus_req_t bus_req,
    output logic [31:0] bus_rdata,
    // Current and temperature measurements.
    input wire tmb_pkg::tmb_meas_t meas,
    // Model results.
    output logic [15:0] thermal_capacity_used,
    output logic [15:0] equivalent_heating_current,
    output logic overload_trip
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------

    // Bit-serial integer square root.
    function automatic logic [24:0] isqrt(input logic [49:0] v);
        logic [24:0] r;
        logic [24:0] t;
        r = '0;
        for (int b = 24; b >= 0; b--) begin
            t = r | (25'(1) << b);
            if (50'(t) * 50'(t) <= v) begin
                r = t;
            end
        end
        return r;
    endfunction

    // Settle value: current times one minus ratio, as percent.
    function automatic logic [23:0] settle_of(input logic [15:0] ieq, input logic [15:0] hc);
        logic [31:0] frac;
        logic [31:0] pct;
        frac = (hc >= tmb_pkg::Q8_ONE) ? 32'h0 : 32'(ieq) * 32'(tmb_pkg::Q8_ONE - hc);
        pct = frac * tmb_pkg::PCT_SCALE;
        return (pct > 32'(tmb_pkg::TC_FULL)) ? tmb_pkg::TC_FULL : pct[23:0];
    endfunction

    // Guard a divisor against zero.
    function automatic logic [15:0] nz(input logic [15:0] v);
        return (v == 16'h0) ? 16'h0001 : v;
    endfunction

    // ------------------------------------------------------------------
    // Settings registers
    // ------------------------------------------------------------------
    logic [1:0] ctrl_r, ctrl_nxt;
    logic [15:0] fla_r, fla_nxt;
    logic [15:0] kset_r, kset_nxt;
    logic [15:0] hc_r, hc_nxt;
    logic [15:0] pickup_r, pickup_nxt;
    logic [15:0] sf_r, sf_nxt;
    logic [15:0] tau_stop_r, tau_stop_nxt;
    logic [15:0] tau_run_r, tau_run_nxt;
    logic [15:0] bmin_r, bmin_nxt;
    logic [15:0] bcen_r, bcen_nxt;
    logic [15:0] bmax_r, bmax_nxt;
    logic [31:0] rdata_r, rdata_nxt;

    // Model state.
    logic [23:0] tc_r, tc_nxt;
    logic [15:0] ieq_r, ieq_nxt;
    logic trip_r, trip_nxt;
    logic bias_full_r, bias_full_nxt;
    logic [31:0] tick_cnt_r, tick_cnt_nxt;
    tmb_pkg::tmb_motor_state_t prev_state_r, prev_state_nxt;
    logic [15:0] ltau_stop_r, ltau_stop_nxt;
    logic [15:0] ltau_run_r, ltau_run_nxt;

    // Combinational intermediates.
    logic running;
    logic [15:0] k_learn;
    logic [15:0] k_use;
    logic [31:0] ratio;
    logic [15:0] ratio_q8;
    logic [49:0] radicand;
    logic [24:0] root;
    logic [40:0] ieq_wide;
    logic [23:0] settle;
    logic [23:0] center_val;
    logic [23:0] temp_val;
    logic above_pickup;
    logic [15:0] tau_sel;

    // ------------------------------------------------------------------
    // Register port: decode writes, return read data one cycle later
    // ------------------------------------------------------------------
    always_comb begin
        ctrl_nxt = ctrl_r;
        fla_nxt = fla_r;
        kset_nxt = kset_r;
        hc_nxt = hc_r;
        pickup_nxt = pickup_r;
        sf_nxt = sf_r;
        tau_stop_nxt = tau_stop_r;
        tau_run_nxt = tau_run_r;
        bmin_nxt = bmin_r;
        bcen_nxt = bcen_r;
        bmax_nxt = bmax_r;
        rdata_nxt = 32'h0;
        if (bus_req.wr) begin
            unique case (bus_req.addr)
                tmb_pkg::ADDR_CTRL: ctrl_nxt = bus_req.wdata[1:0];
                tmb_pkg::ADDR_FLA: fla_nxt = bus_req.wdata[15:0];
                tmb_pkg::ADDR_K_FACTOR: kset_nxt = bus_req.wdata[15:0];
                tmb_pkg::ADDR_HOT_COLD: hc_nxt = bus_req.wdata[15:0];
                tmb_pkg::ADDR_OL_PICKUP: pickup_nxt = bus_req.wdata[15:0];
                tmb_pkg::ADDR_SERVICE: sf_nxt = bus_req.wdata[15:0];
                tmb_pkg::ADDR_TAU_STOP: tau_stop_nxt = bus_req.wdata[15:0];
                tmb_pkg::ADDR_TAU_RUN: tau_run_nxt = bus_req.wdata[15:0];
                tmb_pkg::ADDR_BIAS_MIN: bmin_nxt = bus_req.wdata[15:0];
                tmb_pkg::ADDR_BIAS_CEN: bcen_nxt = bus_req.wdata[15:0];
                tmb_pkg::ADDR_BIAS_MAX: bmax_nxt = bus_req.wdata[15:0];
                default: ;
            endcase
        end
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                tmb_pkg::ADDR_CTRL: rdata_nxt = {30'h0, ctrl_r};
                tmb_pkg::ADDR_FLA: rdata_nxt = {16'h0, fla_r};
                tmb_pkg::ADDR_K_FACTOR: rdata_nxt = {16'h0, kset_r};
                tmb_pkg::ADDR_HOT_COLD: rdata_nxt = {16'h0, hc_r};
                tmb_pkg::ADDR_OL_PICKUP: rdata_nxt = {16'h0, pickup_r};
                tmb_pkg::ADDR_SERVICE: rdata_nxt = {16'h0, sf_r};
                tmb_pkg::ADDR_TAU_STOP: rdata_nxt = {16'h0, tau_stop_r};
                tmb_pkg::ADDR_TAU_RUN: rdata_nxt = {16'h0, tau_run_r};
                tmb_pkg::ADDR_BIAS_MIN: rdata_nxt = {16'h0, bmin_r};
                tmb_pkg::ADDR_BIAS_CEN: rdata_nxt = {16'h0, bcen_r};
                tmb_pkg::ADDR_BIAS_MAX: rdata_nxt = {16'h0, bmax_r};
                tmb_pkg::ADDR_TC: rdata_nxt = {16'h0, tc_r[23:8]};
                tmb_pkg::ADDR_IEQ: rdata_nxt = {16'h0, ieq_r};
                tmb_pkg::ADDR_K_USED: rdata_nxt = {16'h0, k_use};
                tmb_pkg::ADDR_TAU_LEARN: rdata_nxt = {ltau_run_r, ltau_stop_r};
                tmb_pkg::ADDR_STATUS: begin
                    rdata_nxt[tmb_pkg::ST_TRIP_BIT] = trip_r;
                    rdata_nxt[tmb_pkg::ST_BIAS_FULL_BIT] = bias_full_r;
                    rdata_nxt[tmb_pkg::ST_HEATING_BIT] = above_pickup;
                end
                default: ;
            endcase
        end
    end

    // Settings and read data registers.
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r <= tmb_pkg::RST_CTRL;
            fla_r <= tmb_pkg::RST_FLA;
            kset_r <= tmb_pkg::RST_K;
            hc_r <= tmb_pkg::RST_HOT_COLD;
            pickup_r <= tmb_pkg::RST_PICKUP;
            sf_r <= tmb_pkg::RST_SERVICE;
            tau_stop_r <= tmb_pkg::RST_TAU_STOP;
            tau_run_r <= tmb_pkg::RST_TAU_RUN;
            bmin_r <= tmb_pkg::RST_BIAS_MIN;
            bcen_r <= tmb_pkg::RST_BIAS_CEN;
            bmax_r <= tmb_pkg::RST_BIAS_MAX;
            rdata_r <= 32'h0;
        end else begin
            ctrl_r <= ctrl_nxt;
            fla_r <= fla_nxt;
            kset_r <= kset_nxt;
            hc_r <= hc_nxt;
            pickup_r <= pickup_nxt;
            sf_r <= sf_nxt;
            tau_stop_r <= tau_stop_nxt;
            tau_run_r <= tau_run_nxt;
            bmin_r <= bmin_nxt;
            bcen_r <= bcen_nxt;
            bmax_r <= bmax_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Equivalent heating current
    // ------------------------------------------------------------------

    // Learned k, k selection and biased heating current.
    always_comb begin
        logic [63:0] num, den, kq;
        running = (meas.motor_state == tmb_pkg::TMB_RUNNING);
        num = (tmb_pkg::LEARN_K_NUM << tmb_pkg::Q8_SHIFT) * 64'(fla_r) * 64'(fla_r);
        den = 64'(meas.learned_start_current) * 64'(meas.learned_start_current);
        kq = (den == 64'h0) ? 64'(kset_r) : num / den;
        k_learn = (kq > 64'(tmb_pkg::K_MAX)) ? tmb_pkg::K_MAX : kq[15:0];
        k_use = ctrl_r[tmb_pkg::CTRL_K_LEARN_BIT] ? k_learn : kset_r;
        ratio = (32'(meas.i_avg) << tmb_pkg::Q8_SHIFT) / 32'(nz(fla_r));
        ratio_q8 = (ratio > 32'(16'hFFFF)) ? 16'hFFFF : ratio[15:0];
        // Unbalance is Q8, its square Q16, k times it Q24.
        radicand = tmb_pkg::RADICAND_ONE
            + 50'(k_use) * 50'(meas.unbalance_fraction) * 50'(meas.unbalance_fraction);
        root = isqrt(radicand);
        ieq_wide = (41'(ratio_q8) * 41'(root)) >> tmb_pkg::SQRT_SHIFT;
        if (k_use == 16'h0 || !running) begin
            ieq_nxt = ratio_q8;
        end else begin
            ieq_nxt = (ieq_wide > 41'(16'hFFFF)) ? 16'hFFFF : ieq_wide[15:0];
        end
    end

    // ------------------------------------------------------------------
    // Settle value, temperature curve and time constant selection
    // ------------------------------------------------------------------
    always_comb begin
        logic [39:0] span, part;
        span = 40'h0;
        part = 40'h0;
        settle = running ? settle_of(ieq_r, hc_r) : 24'h0;
        center_val = settle_of(tmb_pkg::Q8_ONE, hc_r);
        if (meas.stator_temp < bcen_r) begin
            span = 40'(meas.stator_temp - bmin_r) * 40'(center_val);
            part = span / 40'(nz(bcen_r - bmin_r));
            temp_val = part[23:0];
        end else begin
            span = 40'(meas.stator_temp - bcen_r) * 40'(tmb_pkg::TC_FULL - center_val);
            part = span / 40'(nz(bmax_r - bcen_r));
            temp_val = (part > 40'(tmb_pkg::TC_FULL - center_val)) ? tmb_pkg::TC_FULL
                : part[23:0] + center_val;
        end
        above_pickup = (meas.motor_state != tmb_pkg::TMB_STOPPED) && (ieq_r > pickup_r);
        // Each constant is a fifth of the full cool time.
        if (running) begin
            tau_sel = nz(ctrl_r[tmb_pkg::CTRL_COOL_LEARN_BIT] ? ltau_run_r : tau_run_r);
        end else begin
            tau_sel = nz(ctrl_r[tmb_pkg::CTRL_COOL_LEARN_BIT] ? ltau_stop_r : tau_stop_r);
        end
    end

    // ------------------------------------------------------------------
    // Model state: tick timing, capacity update, learning and trip
    // ------------------------------------------------------------------
    always_comb begin
        logic [23:0] diff;
        logic [47:0] step, run_tau;
        logic [24:0] heated;
        logic [15:0] amb;
        logic [31:0] base;
        logic [15:0] ref_load;
        tick_cnt_nxt = tick_cnt_r + 32'h1;
        tc_nxt = tc_r;
        bias_full_nxt = bias_full_r;
        prev_state_nxt = meas.motor_state;
        ltau_stop_nxt = ltau_stop_r;
        ltau_run_nxt = ltau_run_r;
        diff = 24'h0;
        step = 48'h0;
        heated = 25'h0;
        if (tick_cnt_r >= 32'(TICK_CYCLES - 1)) begin
            tick_cnt_nxt = 32'h0;
            if (above_pickup) begin
                // Heating comes from the outside curve element.
                heated = 25'(tc_r) + 25'(meas.curve_heat);
                tc_nxt = (heated > 25'(tmb_pkg::TC_FULL)) ? tmb_pkg::TC_FULL : heated[23:0];
            end else if (running && settle > tc_r) begin
                diff = settle - tc_r;
                tc_nxt = tc_r + ((diff < tmb_pkg::TC_RISE_PER_TICK) ? diff : tmb_pkg::TC_RISE_PER_TICK);
            end else if (tc_r > settle) begin
                // One exponential tick: the gap shrinks by dt over tau.
                diff = tc_r - settle;
                step = 48'(diff) / (48'(tmb_pkg::TICKS_PER_MIN) * 48'(tau_sel));
                tc_nxt = tc_r - ((step == 48'h0) ? 24'h1 : step[23:0]);
            end
            // Temperature bias acts after the current model.
            bias_full_nxt = 1'b0;
            if (meas.stator_temp > bmax_r) begin
                tc_nxt = tmb_pkg::TC_FULL;
                bias_full_nxt = 1'b1;
            end else if (meas.stator_temp >= bmin_r && temp_val > tc_nxt) begin
                tc_nxt = temp_val;
            end
        end
        // Learned cooling: tau is rise over ambient divided by cooling rate.
        amb = meas.ambient_valid ? meas.ambient_temp : tmb_pkg::AMBIENT_DEFAULT;
        base = (meas.stator_temp > amb)
            ? (32'(meas.stator_temp - amb) << tmb_pkg::Q8_SHIFT) / 32'(nz(meas.stator_cool_rate))
            : 32'h1;
        ref_load = (sf_r != 16'h0) ? sf_r : pickup_r;
        run_tau = ((48'(base) * 48'(hc_r)) >> tmb_pkg::Q8_SHIFT) * 48'(ref_load)
            / 48'(nz((ieq_r > ref_load) ? ieq_r : ref_load));
        if (prev_state_r == tmb_pkg::TMB_STARTING && meas.motor_state == tmb_pkg::TMB_RUNNING) begin
            ltau_run_nxt = nz((run_tau > 48'(16'hFFFF)) ? 16'hFFFF : run_tau[15:0]);
        end
        if (prev_state_r == tmb_pkg::TMB_RUNNING && meas.motor_state == tmb_pkg::TMB_STOPPED) begin
            ltau_stop_nxt = nz((base > 32'(16'hFFFF)) ? 16'hFFFF : base[15:0]);
        end
        // A full model trips only with current above pickup.
        trip_nxt = (tc_r >= tmb_pkg::TC_FULL) && above_pickup;
    end

    // Model state registers.
    always_ff @(posedge clk) begin
        if (rst) begin
            tc_r <= 24'h0;
            ieq_r <= 16'h0;
            trip_r <= 1'b0;
            bias_full_r <= 1'b0;
            tick_cnt_r <= 32'h0;
            prev_state_r <= tmb_pkg::TMB_STOPPED;
            ltau_stop_r <= tmb_pkg::RST_TAU_STOP;
            ltau_run_r <= tmb_pkg::RST_TAU_RUN;
        end else begin
            tc_r <= tc_nxt;
            ieq_r <= ieq_nxt;
            trip_r <= trip_nxt;
            bias_full_r <= bias_full_nxt;
            tick_cnt_r <= tick_cnt_nxt;
            prev_state_r <= prev_state_nxt;
            ltau_stop_r <= ltau_stop_nxt;
            ltau_run_r <= ltau_run_nxt;
        end
    end

    // Outputs come straight from registers.
    assign bus_rdata = rdata_r;
    assign thermal_capacity_used = tc_r[23:8];
    assign equivalent_heating_current = ieq_r;
    assign overload_trip = trip_r;

endmodule

`default_nettype wire

/* tb/tmb_meas_model.sv */
// Measurement front end model.
`default_nettype none
module tmb_meas_model (
    // Clock.
    input wire logic clk,
    // Conditions asked for by the bench.
    input wire logic [15:0] i_avg,
    input wire logic [15:0] ub,
    input wire logic [15:0] temp,
    input wire logic [15:0] lsc,
    input wire logic [15:0] heat,
    input wire tmb_pkg::tmb_motor_state_t state,
    // Readings presented to the block.
    output var tmb_pkg::tmb_meas_t meas
);
    timeunit 1ns;
    timeprecision 1ns;
    // Cleared so no unknown reaches the block.
    initial meas = '0;
    // No ambient sensor; the stator cools at a fixed rate.
    always @(posedge clk) begin
        meas <= {i_avg, ub, temp, 16'h0000, 1'b0, 16'h0200, lsc, state, heat};
    end
endmodule
`default_nettype wire

/* tb/tmb_properties.sv */
// Port checker and its bind.
`default_nettype none
module tmb_properties #(
    parameter int TICK_CYCLES = tmb_pkg::TICK_CYCLES
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Register port.
    input wire tmb_pkg::tmb_bus_req_t bus_req,
    input wire logic [31:0] bus_rdata,
    // Measurements and results.
    input wire tmb_pkg::tmb_meas_t meas,
    input wire logic [15:0] thermal_capacity_used,
    input wire logic [15:0] equivalent_heating_current,
    input wire logic overload_trip
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] fla_r, k_r, min_r, max_r, prev_r;
    logic lrn_r, seen_r;
    int gap_r, hot_r;
    logic [31:0] pu;
    // Unbiased per-unit current; zero full load counts as one.
    assign pu = {meas.i_avg, 8'h00} / ((fla_r == 16'h0000) ? 32'h1 : {16'h0000, fla_r});
    // Shadows settings and times capacity steps.
    always_ff @(posedge clk) begin
        if (rst) begin
            fla_r <= tmb_pkg::RST_FLA;
            k_r <= tmb_pkg::RST_K;
            min_r <= tmb_pkg::RST_BIAS_MIN;
            max_r <= tmb_pkg::RST_BIAS_MAX;
            lrn_r <= 1'b0;
            prev_r <= 16'h0000;
            seen_r <= 1'b0;
            gap_r <= 0;
            hot_r <= 0;
        end else begin
            if (bus_req.wr && bus_req.addr == tmb_pkg::ADDR_FLA) fla_r <= bus_req.wdata[15:0];
            if (bus_req.wr && bus_req.addr == tmb_pkg::ADDR_K_FACTOR) k_r <= bus_req.wdata[15:0];
            if (bus_req.wr && bus_req.addr == tmb_pkg::ADDR_BIAS_MIN) min_r <= bus_req.wdata[15:0];
            if (bus_req.wr && bus_req.addr == tmb_pkg::ADDR_BIAS_MAX) max_r <= bus_req.wdata[15:0];
            if (bus_req.wr && bus_req.addr == tmb_pkg::ADDR_CTRL) lrn_r <= bus_req.wdata[0];
            prev_r <= thermal_capacity_used;
            seen_r <= seen_r || (thermal_capacity_used != prev_r);
            gap_r <= (thermal_capacity_used != prev_r) ? 1 : gap_r + 1;
            hot_r <= (meas.stator_temp > max_r) ? hot_r + 1 : 0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    rd_idle_a: assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h0)
        else $error("read data outside its slot");
    fla_read_a: assert property (bus_req.rd && bus_req.addr == tmb_pkg::ADDR_FLA |=> bus_rdata == {16'h0, $past(fla_r)})
        else $error("full load setting read back wrong");
    plain_ieq_a:
        assert property ((meas.motor_state != tmb_pkg::TMB_RUNNING || (k_r == 16'h0 && !lrn_r)) && pu <= 32'hFFFF
            |=> equivalent_heating_current == $past(pu[15:0])) else $error("unbiased heating current wrong");
    tick_space_a: assert property (seen_r && thermal_capacity_used != prev_r |-> gap_r % TICK_CYCLES == 0)
        else $error("capacity stepped off a tick");
    cap_max_a: assert property (thermal_capacity_used <= tmb_pkg::TC_FULL[23:8])
        else $error("capacity above full");
    hot_full_a: assert property (hot_r > TICK_CYCLES |-> thermal_capacity_used == 16'h6400)
        else $error("hot stator did not force full capacity");
    trip_cause_a:
        assert property (overload_trip |-> $past(meas.motor_state) != tmb_pkg::TMB_STOPPED
            && $past(thermal_capacity_used) == 16'h6400) else $error("trip without its cause");
    cold_decay_a:
        assert property ($past(meas.motor_state) == tmb_pkg::TMB_STOPPED && $past(meas.stator_temp) < $past(min_r)
            |-> thermal_capacity_used <= $past(thermal_capacity_used)) else $error("stopped cold motor heated");
endmodule
bind tmb_thermal_model tmb_properties #(.TICK_CYCLES(TICK_CYCLES)) tmb_properties_i (.clk, .rst, .bus_req,
    .bus_rdata, .meas, .thermal_capacity_used, .equivalent_heating_current, .overload_trip);
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench of the thermal model block.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TK = 10;
    logic clk, rst, trip;
    logic [31:0] bus_rdata, d;
    logic [15:0] tcu, ieq, i_avg, ub, temp, lsc, heat, v;
    logic [15:0] rv [11];
    tmb_pkg::tmb_bus_req_t bus_req;
    tmb_pkg::tmb_meas_t meas;
    tmb_pkg::tmb_motor_state_t st;
    int fail_count, checks_done, seed, i, e;
    tmb_thermal_model #(.TICK_CYCLES(TK)) tmb_thermal_model_i (.clk, .rst, .bus_req, .bus_rdata, .meas,
        .thermal_capacity_used(tcu), .equivalent_heating_current(ieq), .overload_trip(trip));
    tmb_meas_model tmb_meas_model_i (.clk, .i_avg, .ub, .temp, .lsc, .heat, .state(st), .meas);
    // Bench clock.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic wr(input logic [7:0] a, input logic [15:0] x);
        @(posedge clk);
        bus_req <= '{a, {16'h0, x}, 1'b1, 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        bus_req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1 d = bus_rdata;
    endtask
    task automatic ticks(input int n);
        repeat (n * TK) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [31:0] g, input int lo, input int hi);
        checks_done++;
        if (((g >= lo) && (g <= hi)) !== 1'b1) begin
            fail_count++;
            $display("unexpected at %0t: got %0d want %0d..%0d", $time, g, lo, hi);
        end
    endtask
    function automatic int exp_ieq(input int x, input int u, input int k, input int f);
        return $rtoi(x * 256.0 / f * $sqrt(1.0 + k * u * u / 16777216.0) + 1.0e-6);
    endfunction
    function automatic int cool(input int s, input int f, input int n, input int tau);
        return $rtoi(f + (s - f) * $exp(-n / (600.0 * tau)));
    endfunction
    function automatic int bias(input int t, input int hc);
        int c, mn, cn, mx;
        mn = int'(tmb_pkg::RST_BIAS_MIN);
        cn = int'(tmb_pkg::RST_BIAS_CEN);
        mx = int'(tmb_pkg::RST_BIAS_MAX);
        c = (256 - hc) * 100;
        if (t <= cn) return c * (t - mn) / (cn - mn);
        return c + (25600 - c) * (t - cn) / (mx - cn);
    endfunction
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Watchdog against a hung run.
    initial begin
        #2400000;
        fail_count++;
        complete_run();
    end
    // Main sequence.
    initial begin
        seed = 32'hF905FCA9;
        fail_count = 0;
        checks_done = 0;
        rv = '{16'(tmb_pkg::RST_CTRL), tmb_pkg::RST_FLA, tmb_pkg::RST_K, tmb_pkg::RST_HOT_COLD,
            tmb_pkg::RST_PICKUP, tmb_pkg::RST_SERVICE, tmb_pkg::RST_TAU_STOP, tmb_pkg::RST_TAU_RUN,
            tmb_pkg::RST_BIAS_MIN, tmb_pkg::RST_BIAS_CEN, tmb_pkg::RST_BIAS_MAX};
        rst = 1'b1;
        bus_req = '0;
        i_avg = 16'h0064;
        ub = 16'h0000;
        temp = 16'h0014;
        lsc = 16'h0000;
        heat = 16'h0000;
        st = tmb_pkg::TMB_STOPPED;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 11; i++) begin
            rd(8'(i * 4));
            chk(d, rv[i], rv[i]);
        end
        wr(8'h40, 16'h1234);
        rd(8'h40);
        chk(d, 0, 0);
        wr(tmb_pkg::ADDR_TC, 16'h1234);
        rd(tmb_pkg::ADDR_TC);
        chk(d, 0, 0);
        for (i = 0; i < 20; i++) begin
            v = 16'(100 + {$random(seed)} % 256);
            wr(tmb_pkg::ADDR_FLA, v);
            i_avg <= 16'({$random(seed)} % 1000);
            rd(tmb_pkg::ADDR_FLA);
            chk(d, v, v);
            e = exp_ieq(i_avg, 0, 0, v);
            chk(ieq, e, e);
        end
        wr(tmb_pkg::ADDR_HOT_COLD, 16'h0100);
        wr(tmb_pkg::ADDR_FLA, 16'h0064);
        wr(tmb_pkg::ADDR_K_FACTOR, 16'h0800);
        i_avg <= 16'h0064;
        ub <= 16'h0080;
        rd(tmb_pkg::ADDR_K_FACTOR);
        chk(ieq, 16'h0100, 16'h0100);
        st <= tmb_pkg::TMB_RUNNING;
        rd(tmb_pkg::ADDR_IEQ);
        e = exp_ieq(100, 128, 2048, 100);
        chk(ieq, e - 2, e + 2);
        wr(tmb_pkg::ADDR_K_FACTOR, 16'h0000);
        rd(tmb_pkg::ADDR_IEQ);
        chk(ieq, 16'h0100, 16'h0100);
        lsc <= 16'h0258;
        ub <= 16'h0100;
        for (i = 0; i < 5; i++) begin
            st <= tmb_pkg::TMB_STARTING;
            ticks(1);
            st <= tmb_pkg::TMB_RUNNING;
            ticks(1);
        end
        wr(tmb_pkg::ADDR_CTRL, 16'h0001);
        ticks(1);
        rd(tmb_pkg::ADDR_K_USED);
        chk(d, 1243, 1245);
        e = exp_ieq(100, 256, 1244, 100);
        chk(ieq, e - 3, e + 3);
        wr(tmb_pkg::ADDR_CTRL, 16'h0000);
        ub <= 16'h0000;
        wr(tmb_pkg::ADDR_HOT_COLD, 16'h00F0);
        ticks(60);
        e = int'(tmb_pkg::TC_RISE_PER_TICK);
        chk(tcu, 60 * e / 256 - 1, 62 * e / 256);
        ticks(800);
        chk(tcu, 16'h063F, 16'h0640);
        temp <= 16'h009C;
        ticks(2);
        chk(tcu, 16'h6400, 16'h6400);
        chk(trip, 0, 0);
        temp <= 16'h0014;
        wr(tmb_pkg::ADDR_TAU_RUN, 16'h0001);
        ticks(600);
        e = cool(25600, 1600, 600, 1);
        chk(tcu, e - 300, e + 300);
        st <= tmb_pkg::TMB_STOPPED;
        ticks(600);
        e = cool(e, 0, 600, 30);
        chk(tcu, e - 350, e + 350);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        wr(tmb_pkg::ADDR_HOT_COLD, 16'h0080);
        for (i = 0; i < 3; i++) begin
            v = (i == 0) ? 16'h0055 : (i == 1) ? 16'h0082 : 16'h008F;
            temp <= v;
            ticks(2);
            e = bias(v, 128);
            chk(tcu, e - 32, e + 1);
        end
        temp <= 16'h0064;
        ticks(2);
        chk(tcu, e - 64, e + 1);
        temp <= 16'h0014;
        ticks(3);
        st <= tmb_pkg::TMB_RUNNING;
        i_avg <= 16'h00C8;
        heat <= 16'hFFFF;
        for (i = 0; i < 4000 && trip !== 1'b1; i++) @(posedge clk);
        #1;
        chk(tcu, 16'h6400, 16'h6400);
        chk(trip, 1, 1);
        i_avg <= 16'h0064;
        ticks(1);
        chk(trip, 0, 0);
        complete_run();
    end
endmodule
`default_nettype wire
